// *** hw/obc_pkg.sv ***
// Package for the boot configuration byte loader: offsets, fields, timing
package obc_pkg;

  // Flash address of the configuration byte
  localparam logic [15:0] OBC_FLASH_ADDR = 16'h0080;

  // APB register byte offsets
  localparam logic [7:0] OBC_REG_CFG_BYTE = 8'h80;
  localparam logic [7:0] OBC_REG_CTRL = 8'h00;
  localparam logic [7:0] OBC_REG_STATUS = 8'h04;
  localparam logic [7:0] OBC_REG_PINS = 8'h08;

  // Configuration byte field positions
  localparam int OBC_BIT_LOCK = 0;
  localparam int OBC_BIT_SRC_LO = 1;
  localparam int OBC_BIT_SRC_HI = 2;
  localparam int OBC_BIT_RSTPIN = 3;
  localparam int OBC_BIT_SETTLE_LO = 5;
  localparam int OBC_BIT_SETTLE_HI = 6;

  // Control register field positions
  localparam int OBC_CTRL_STOP = 0;
  localparam int OBC_CTRL_WDT_SLOW = 1;
  localparam int OBC_CTRL_TMR_SLOW = 2;

  // Reset values
  localparam logic [7:0] OBC_CFG_RESET = 8'hff;
  localparam logic [2:0] OBC_CTRL_RESET = 3'h6;

  // Settling exponents per code, in main oscillator cycles
  localparam int OBC_SETTLE_EXP0 = 10;
  localparam int OBC_SETTLE_EXP1 = 12;
  localparam int OBC_SETTLE_EXP2 = 15;
  localparam int OBC_SETTLE_EXP3 = 17;

  // System clock source encodings
  typedef enum logic [1:0]
  {
    OBC_SRC_XTAL = 2'b00,
    OBC_SRC_EXT = 2'b01,
    OBC_SRC_FAST = 2'b10,
    OBC_SRC_FAST2 = 2'b11
  } obc_src_t;

  // Decoded settings
  typedef struct packed
  {
    logic slowOscLock;
    obc_src_t sysclkSource;
    logic resetPinFunction;
    logic [1:0] oscSettleSel;
  } obc_cfg_t;

  // Pin ownership towards the port logic
  typedef struct packed
  {
    logic oscInPinClock;
    logic oscOutPinClock;
    logic oscInAltFunction;
    logic oscOutAltFunction;
    logic resetPinPortInput;
  } obc_pins_t;

endpackage

// *** hw/obc_option_byte_config.sv ***
// Boot configuration byte loader and decoder with APB register access
`timescale 1ns/10ps
`default_nettype none

module obc_option_byte_config
  import obc_pkg::*;
#(
  parameter int FLASH_WAIT = 2
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Power-on clear and main oscillator tick
  input wire logic porRelease,
  input wire logic mainOscTick,
  // Flash read port
  output logic flashReq,
  output logic [15:0] flashAddr,
  input wire logic [7:0] flashData,
  // Reset pin, raw from outside
  input wire logic resetPinRaw,
  // Power mode from the core
  input wire logic haltOrStop,
  // Clock and reset outputs
  output logic cpuRun,
  output logic chipReset,
  output logic slowOscEnable,
  output logic wdtClockEnable,
  output logic wdtClockFromSlow,
  output logic timerSlowClockEnable,
  output logic [1:0] sysclkSource,
  output obc_pins_t pinsOwner,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata
);

  typedef enum {ST_IDLE, ST_READ, ST_SETTLE, ST_RUN} obc_state_t;

  obc_state_t state;
  logic [7:0] cfgByte;
  obc_cfg_t cfg;
  logic [3:0] readCnt;
  logic [17:0] settleCnt;
  logic [17:0] settleLimit;
  logic [2:0] ctrl;
  logic pinSync1;
  logic pinSync2;
  logic porSync1;
  logic porSync2;
  logic pinHold;
  logic apbAccess;

  // Settling length for a code
  function automatic logic [17:0] settle_cycles(input logic [1:0] code);
    unique case (code)
      2'b00: settle_cycles = 18'(1 << OBC_SETTLE_EXP0);
      2'b01: settle_cycles = 18'(1 << OBC_SETTLE_EXP1);
      2'b10: settle_cycles = 18'(1 << OBC_SETTLE_EXP2);
      2'b11: settle_cycles = 18'(1 << OBC_SETTLE_EXP3);
    endcase
  endfunction

  // Register decode shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OBC_REG_CFG_BYTE) || (a == OBC_REG_CTRL) || (a == OBC_REG_STATUS) || (a == OBC_REG_PINS);
  endfunction

  // Field split of the latched byte; bits 7 and 4 are ignored
  assign cfg.slowOscLock = cfgByte[OBC_BIT_LOCK];
  assign cfg.sysclkSource = obc_src_t'({cfgByte[OBC_BIT_SRC_HI], cfgByte[OBC_BIT_SRC_LO]});
  assign cfg.resetPinFunction = cfgByte[OBC_BIT_RSTPIN];
  assign cfg.oscSettleSel = {cfgByte[OBC_BIT_SETTLE_HI], cfgByte[OBC_BIT_SETTLE_LO]};
  assign settleLimit = settle_cycles(cfg.oscSettleSel);
  assign apbAccess = psel && penable;

  // Pin and power-on inputs come from outside this clock
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
      porSync1 <= 1'b0;
      porSync2 <= 1'b0;
    end
    else
    begin
      pinSync1 <= resetPinRaw;
      pinSync2 <= pinSync1;
      porSync1 <= porRelease;
      porSync2 <= porSync1;
    end
  end

  // Load sequence: fetch byte, settle, then let the core run
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cfgByte <= OBC_CFG_RESET;
      readCnt <= 4'h0;
      settleCnt <= 18'h0_0000;
      flashReq <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          // Pin low before reload keeps the chip in reset
          if (porSync2 && pinSync2)
          begin
            state <= ST_READ;
            flashReq <= 1'b1;
            readCnt <= 4'h0;
          end
        end
        ST_READ:
        begin
          if (readCnt == 4'(FLASH_WAIT))
          begin
            cfgByte <= flashData;
            flashReq <= 1'b0;
            settleCnt <= 18'h0_0000;
            state <= ST_SETTLE;
          end
          else
          begin
            readCnt <= readCnt + 4'h1;
          end
        end
        ST_SETTLE:
        begin
          // Only a crystal needs to settle
          if (cfg.sysclkSource != OBC_SRC_XTAL)
          begin
            state <= ST_RUN;
          end
          else if (mainOscTick)
          begin
            if (settleCnt == settleLimit - 18'h0_0001)
            begin
              state <= ST_RUN;
            end
            settleCnt <= settleCnt + 18'h0_0001;
          end
        end
        ST_RUN:
        begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Run and reset outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cpuRun <= 1'b0;
      chipReset <= 1'b1;
      pinHold <= 1'b0;
    end
    else
    begin
      cpuRun <= (state == ST_RUN);
      // Once loaded, pin only resets the chip if it is a reset pin
      pinHold <= (state != ST_RUN) && !pinSync2;
      chipReset <= (state != ST_RUN) || (cfg.resetPinFunction && !pinSync2);
    end
  end

  // Software control register: stop request, watchdog and timer clock choice
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= OBC_CTRL_RESET;
    end
    else if (apbAccess && pwrite && paddr == OBC_REG_CTRL)
    begin
      ctrl <= pwdata[2:0];
    end
  end

  // Slow oscillator run control
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      slowOscEnable <= 1'b1;
    end
    else
    begin
      // A locked oscillator ignores the stop request
      slowOscEnable <= cfg.slowOscLock || !ctrl[OBC_CTRL_STOP];
    end
  end

  // Watchdog count clock source
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wdtClockFromSlow <= 1'b1;
    end
    else
    begin
      wdtClockFromSlow <= cfg.slowOscLock || ctrl[OBC_CTRL_WDT_SLOW];
    end
  end

  // Watchdog count clock gate; held off until the core runs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wdtClockEnable <= 1'b0;
    end
    else if (state != ST_RUN)
    begin
      wdtClockEnable <= 1'b0;
    end
    else if (cfg.slowOscLock)
    begin
      // Unstoppable oscillator: no software setting can starve the watchdog
      wdtClockEnable <= 1'b1;
    end
    else
    begin
      wdtClockEnable <= !haltOrStop && ctrl[OBC_CTRL_WDT_SLOW] && !ctrl[OBC_CTRL_STOP];
    end
  end

  // Timer slow clock gate
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timerSlowClockEnable <= 1'b0;
    end
    else
    begin
      // No halt term: the timer keeps counting in low power while the oscillator runs
      timerSlowClockEnable <= ctrl[OBC_CTRL_TMR_SLOW] &&
                              (cfg.slowOscLock || !ctrl[OBC_CTRL_STOP]);
    end
  end

  // Clock source and oscillator pin ownership
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sysclkSource <= 2'b10;
      pinsOwner <= '0;
      flashAddr <= OBC_FLASH_ADDR;
    end
    else
    begin
      flashAddr <= OBC_FLASH_ADDR;
      sysclkSource <= cfg.sysclkSource;
      unique case (cfg.sysclkSource)
        OBC_SRC_XTAL:
        begin
          pinsOwner.oscInPinClock <= 1'b1;
          pinsOwner.oscOutPinClock <= 1'b1;
          pinsOwner.oscInAltFunction <= 1'b0;
          pinsOwner.oscOutAltFunction <= 1'b0;
        end
        OBC_SRC_EXT:
        begin
          pinsOwner.oscInPinClock <= 1'b1;
          pinsOwner.oscOutPinClock <= 1'b0;
          pinsOwner.oscInAltFunction <= 1'b0;
          pinsOwner.oscOutAltFunction <= 1'b1;
        end
        OBC_SRC_FAST, OBC_SRC_FAST2:
        begin
          pinsOwner.oscInPinClock <= 1'b0;
          pinsOwner.oscOutPinClock <= 1'b0;
          pinsOwner.oscInAltFunction <= 1'b1;
          pinsOwner.oscOutAltFunction <= 1'b1;
        end
      endcase
      pinsOwner.resetPinPortInput <= !cfg.resetPinFunction;
    end
  end

  // APB slave: one wait-free access phase, error on unmapped offsets
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !is_mapped(paddr);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          OBC_REG_CFG_BYTE: prdata <= {24'h00_0000, cfgByte};
          OBC_REG_CTRL: prdata <= {29'h0000_0000, ctrl};
          OBC_REG_STATUS: prdata <= {26'h000_0000, pinHold, slowOscEnable, wdtClockEnable,
                                     timerSlowClockEnable, cpuRun, chipReset};
          OBC_REG_PINS: prdata <= {27'h000_0000, pinsOwner};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // obc_option_byte_config

`default_nettype wire

// *** tb/obc_properties.sv ***
// Port assertions for the boot configuration byte loader
`timescale 1ns/10ps
`default_nettype none
module obc_properties
  import obc_pkg::*;
(
  // Clock, reset, inputs
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic resetPinRaw,
  input wire logic haltOrStop,
  // Outputs
  input wire logic flashReq,
  input wire logic [15:0] flashAddr,
  input wire logic cpuRun,
  input wire logic chipReset,
  input wire logic slowOscEnable,
  input wire logic wdtClockEnable,
  input wire logic wdtClockFromSlow,
  input wire logic timerSlowClockEnable,
  input wire logic [1:0] sysclkSource,
  input wire obc_pins_t pinsOwner
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [10:0] idleCnt;
  // Cycles since the flash read; saturates so it never wraps
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      idleCnt <= '0;
    else if (flashReq)
      idleCnt <= '0;
    else if (idleCnt != 11'h7ff)
      idleCnt <= idleCnt + 11'h001;
  end
  flash_addr_a:
    assert property (flashReq |-> flashAddr == OBC_FLASH_ADDR) else $error("bad flash address");
  fast_pins_a:
    assert property (cpuRun && sysclkSource[1] |-> pinsOwner[4:1] == 4'h3) else $error("fast pins");
  xtal_pins_a:
    assert property (cpuRun && sysclkSource == 2'b00 |-> pinsOwner[4:1] == 4'hc) else $error("xtal pins");
  ext_pins_a:
    assert property (cpuRun && sysclkSource == 2'b01 |-> pinsOwner[4:1] == 4'h9) else $error("ext pins");
  wdt_source_a:
    assert property (!wdtClockFromSlow |-> !wdtClockEnable) else $error("wdt clock on");
  timer_gate_a:
    assert property (timerSlowClockEnable |-> slowOscEnable) else $error("timer");
  pin_reset_a:
    assert property ((!pinsOwner.resetPinPortInput && !resetPinRaw)[*4] |-> chipReset) else $error("pin");
  port_pin_a:
    assert property ((cpuRun && pinsOwner.resetPinPortInput)[*2] |-> !chipReset) else $error("port pin");
  no_wait_a:
    assert property ($fell(flashReq) |-> ##[1:6] (cpuRun || sysclkSource == 2'b00)) else $error("wait");
  xtal_wait_a:
    assert property ($rose(cpuRun) && sysclkSource == 2'b00 |-> idleCnt >= 11'h3fc) else $error("short");
  held_cfg_a:
    assert property (cpuRun && $past(cpuRun) |-> $stable(sysclkSource) && $stable(pinsOwner))
      else $error("cfg moved");
  cover property ($rose(cpuRun) && sysclkSource == 2'b00);
  cover property (haltOrStop && timerSlowClockEnable);
  cover property (cpuRun && chipReset && !resetPinRaw);
endmodule // obc_properties
bind obc_option_byte_config obc_properties u_props (.clk_sys(clk_sys), .rst(rst), .resetPinRaw(resetPinRaw),
  .haltOrStop(haltOrStop), .flashReq(flashReq), .flashAddr(flashAddr), .cpuRun(cpuRun), .chipReset(chipReset),
  .slowOscEnable(slowOscEnable), .wdtClockEnable(wdtClockEnable), .wdtClockFromSlow(wdtClockFromSlow),
  .timerSlowClockEnable(timerSlowClockEnable), .sysclkSource(sysclkSource), .pinsOwner(pinsOwner));
`default_nettype wire

// *** tb/obc_flash_model.sv ***
// Behavioural flash array holding the configuration byte
`timescale 1ns/10ps
`default_nettype none
module obc_flash_model
  import obc_pkg::*;
(
  // Clock and read port
  input wire logic clk_sys,
  input wire logic flashReq,
  input wire logic [15:0] flashAddr,
  output logic [7:0] flashData,
  // Byte programmed by the bench
  input wire logic [7:0] cfgByte
);
  logic [7:0] junk = 8'h5a;
  // Idle bus toggles so a late sample never sees a stale byte
  always_ff @(posedge clk_sys)
    junk <= ~junk;
  // Only the configuration address answers with the stored byte
  assign flashData = (flashReq && flashAddr == OBC_FLASH_ADDR) ? cfgByte : junk;
endmodule // obc_flash_model
`default_nettype wire

// *** tb/option_byte_config_test.sv ***
// Self-checking bench for the boot configuration byte loader
`timescale 1ns/10ps
`default_nettype none
module option_byte_config_test
  import obc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic porRelease = 1'b0;
  logic resetPinRaw = 1'b0;
  logic haltOrStop = 1'b0;
  logic mainOscTick = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] cfgByte = 8'hff;
  logic flashReq, cpuRun, chipReset, slowOscEnable, wdtClockEnable, wdtClockFromSlow, timerSlowClockEnable;
  logic [15:0] flashAddr;
  logic [7:0] flashData;
  logic [1:0] sysclkSource;
  obc_pins_t pinsOwner;
  logic pready, pslverr, err;
  logic [31:0] prdata, rd;
  logic [7:0] b;
  // Bits 7 and 4 programmed high; covers every source code
  logic [7:0] cfgs [4] = '{8'h98, 8'hf3, 8'hdd, 8'h96};
  int mismatches = 0;
  int checks_done = 0;
  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;
  // Main oscillator at half the system rate, so ticks and gaps both occur
  always @(posedge clk_sys)
    mainOscTick <= ~mainOscTick;
  obc_option_byte_config DUT (.clk_sys(clk_sys), .rst(rst), .porRelease(porRelease), .mainOscTick(mainOscTick),
    .flashReq(flashReq), .flashAddr(flashAddr), .flashData(flashData), .resetPinRaw(resetPinRaw),
    .haltOrStop(haltOrStop), .cpuRun(cpuRun), .chipReset(chipReset), .slowOscEnable(slowOscEnable),
    .wdtClockEnable(wdtClockEnable), .wdtClockFromSlow(wdtClockFromSlow),
    .timerSlowClockEnable(timerSlowClockEnable), .sysclkSource(sysclkSource), .pinsOwner(pinsOwner),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata));
  obc_flash_model u_flash (.clk_sys(clk_sys), .flashReq(flashReq), .flashAddr(flashAddr),
    .flashData(flashData), .cfgByte(cfgByte));
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A bounded wait that ran out
  task automatic hang();
    mismatches++;
    stop_test();
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset, hold the pin low a while, then let the byte load
  task automatic boot();
    int n;
    rst <= 1'b1;
    porRelease <= 1'b0;
    resetPinRaw <= 1'b0;
    cfgByte <= b;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    porRelease <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("held", 32'h0000_0001, 32'({flashReq, chipReset}));
    resetPinRaw <= 1'b1;
    n = 0;
    while (cpuRun !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000)
      hang();
    // Code 00 is 2^10 ticks, one tick every second clock
    chk("settle", 32'(b[2:1] == 2'b00), 32'(n >= (2 << OBC_SETTLE_EXP0)));
  endtask
  // Main sequence, one boot per configuration byte
  initial
  begin
    foreach (cfgs[i])
    begin
      b = cfgs[i];
      boot();
      chk("source", 32'(b[2:1]), 32'(sysclkSource));
      apb(1'b0, OBC_REG_CFG_BYTE, 32'h0000_0000);
      chk("byte", 32'(b), rd);
      cfgByte <= 8'h00;
      apb(1'b1, OBC_REG_CFG_BYTE, 32'h0000_0000);
      apb(1'b0, OBC_REG_CFG_BYTE, 32'h0000_0000);
      chk("kept", 32'(b), rd);
      apb(1'b0, OBC_REG_PINS, 32'h0000_0000);
      chk("pins", 32'({!b[2], b[2:1] == 2'b00, b[2], b[2:1] != 2'b00, !b[3]}), rd);
      apb(1'b0, OBC_REG_CTRL, 32'h0000_0000);
      chk("ctrl", 32'(OBC_CTRL_RESET), rd);
      // Running with pin high: oscillator, both clock gates and run set, no reset, no hold
      apb(1'b0, OBC_REG_STATUS, 32'h0000_0000);
      chk("status", 32'h0000_001e, rd);
      apb(1'b0, 8'h0c, 32'h0000_0000);
      chk("unmapped", 32'h8000_0000, {err, rd[30:0]});
      apb(1'b1, OBC_REG_CTRL, 32'h0000_0001);
      repeat (3) @(posedge clk_sys);
      chk("stop", 32'({b[0], b[0]}), 32'({slowOscEnable, wdtClockFromSlow}));
      chk("wdt off", 32'(b[0]), 32'(wdtClockEnable));
      apb(1'b1, OBC_REG_CTRL, 32'h0000_0006);
      repeat (3) @(posedge clk_sys);
      chk("wdt on", 32'h0000_0001, 32'(wdtClockEnable));
      haltOrStop <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("halt", 32'({b[0], 1'b1}), 32'({wdtClockEnable, timerSlowClockEnable}));
      haltOrStop <= 1'b0;
      resetPinRaw <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("pin", 32'(b[3]), 32'(chipReset));
      resetPinRaw <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk("pin high", 32'h0000_0000, 32'(chipReset));
    end
    stop_test();
  end
endmodule // option_byte_config_test
`default_nettype wire
